// *** id14_core.sv ***
// Contract
// - accept 14-bit instruction words split into opcode and operand fields
// - classify each instruction as byte, bit, or literal/control group
// - byte ops: destination select 0 writes accumulator, 1 writes register
// - bit ops: position operand picks one bit of addressed 8-bit register
// - register operand addresses locations 0x00 through 0x7F
// - literal operand is 8 bits for data, 11 bits for branch targets
// - one instruction cycle spans exactly four oscillator periods
// - taken skip or program counter change adds a second no-op cycle
// - register-naming instructions always read, modify, then store; bit tests read but store nothing
// - reading the port register clears the pending pin-change condition
// - don't-care instruction bits decode the same whether 0 or 1
// - port register operand uses actual pin levels, not output latch
// - writing timer-zero count clears its prescaler when assigned to it
`timescale 1ns/1ps
`default_nettype none

module id14_core #(
  parameter int unsigned PC_W = 13,
  parameter int unsigned STACK_DEPTH = 8,
  parameter logic [6:0] PORT_A_ADDR = id14_pkg::PORT_A_ADDR_DEF,
  parameter logic [6:0] TIMER0_ADDR = id14_pkg::TIMER0_ADDR_DEF
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  output logic [PC_W-1:0] prog_addr_o,
  input wire logic [13:0] prog_data_i,
  output logic [6:0] rf_addr_o,
  output logic rf_rd_o,
  output logic rf_wr_o,
  output logic [7:0] rf_wdata_o,
  input wire logic [7:0] rf_rdata_i,
  input wire logic [7:0] port_pins_i,
  input wire logic prescaler_assigned_i,
  output logic pin_change_clear_o,
  output logic prescaler_clear_o,
  output logic wdt_clear_o,
  output logic sleep_req_o,
  output logic cycle_start_o,
  output logic nop_cycle_o,
  output logic [7:0] w_o,
  output id14_pkg::id14_status_t status_o
);

  localparam logic [PC_W-1:0] PC_ONE = 1;
  localparam logic [PC_W-1:0] PC_TWO = 2;

  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    bit_mask = id14_pkg::BYTE_ONE << pos;
  endfunction : bit_mask

  // pin synchroniser
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_meta <= id14_pkg::BYTE_ZERO;
      pin_sync <= id14_pkg::BYTE_ZERO;
    end else begin
      pin_meta <= port_pins_i;
      pin_sync <= pin_meta;
    end
  end

  // sequencer state
  logic [1:0] phase;
  logic [13:0] ir;
  logic flush;
  logic [7:0] opnd;
  logic [1:0] next_phase;
  logic [13:0] next_ir;
  logic next_flush;
  logic [7:0] next_opnd;
  logic [PC_W-1:0] next_pc;
  logic [6:0] next_rf_addr;
  logic next_rf_rd;
  logic next_rf_wr;
  logic [7:0] next_rf_wdata;
  logic next_pin_clr;
  logic next_psc_clr;
  logic next_wdt_clr;
  logic next_sleep;
  logic next_cyc;
  logic next_nop;
  logic [7:0] next_w;
  id14_pkg::id14_status_t next_st;
  logic push;
  logic pop;
  logic [PC_W-1:0] stack_top;

  id14_pkg::id14_dec_t dec;

  id14_decode u_decode (
    .word_i(ir),
    .dec_o(dec)
  );

  id14_stack #(
    .W(PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(prog_addr_o + PC_ONE),
    .top_o(stack_top)
  );

  // execution unit
  logic [7:0] a;
  logic [7:0] res;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic nc;
  logic ndc;
  logic zupd;
  logic skip;

  always_comb begin
    a = (dec.grp == id14_pkg::GRP_LIT) ? dec.lit : opnd;
    res = a;
    nc = status_o.carry;
    ndc = status_o.nibble_overflow_bit;
    zupd = 1'b1;
    skip = 1'b0;
    sum9 = {1'b0, w_o} + {1'b0, a};
    nib5 = {1'b0, w_o[3:0]} + {1'b0, a[3:0]};
    case (dec.op)
      id14_pkg::OP_ADDWF, id14_pkg::OP_ADDLW: begin
        res = sum9[7:0];
        nc = sum9[8];
        ndc = nib5[4];
      end
      id14_pkg::OP_SUBWF, id14_pkg::OP_SUBLW: begin
        sum9 = {1'b0, a} + {1'b0, ~w_o} + 9'h001;
        nib5 = {1'b0, a[3:0]} + {1'b0, ~w_o[3:0]} + 5'h01;
        res = sum9[7:0];
        nc = sum9[8];
        ndc = nib5[4];
      end
      id14_pkg::OP_ANDWF, id14_pkg::OP_ANDLW: res = w_o & a;
      id14_pkg::OP_IORWF, id14_pkg::OP_IORLW: res = w_o | a;
      id14_pkg::OP_XORWF, id14_pkg::OP_XORLW: res = w_o ^ a;
      id14_pkg::OP_REG_CLEAR, id14_pkg::OP_CLRW: res = id14_pkg::BYTE_ZERO;
      id14_pkg::OP_COMF: res = ~a;
      id14_pkg::OP_DECF: res = a - id14_pkg::BYTE_ONE;
      id14_pkg::OP_INCF: res = a + id14_pkg::BYTE_ONE;
      id14_pkg::OP_DECFSZ: begin
        res = a - id14_pkg::BYTE_ONE;
        zupd = 1'b0;
        skip = (res == id14_pkg::BYTE_ZERO);
      end
      id14_pkg::OP_INCFSZ: begin
        res = a + id14_pkg::BYTE_ONE;
        zupd = 1'b0;
        skip = (res == id14_pkg::BYTE_ZERO);
      end
      id14_pkg::OP_MOVF: res = a;
      id14_pkg::OP_MOVWF: begin
        res = w_o;
        zupd = 1'b0;
      end
      id14_pkg::OP_RLF: begin
        res = {a[6:0], status_o.carry};
        nc = a[7];
        zupd = 1'b0;
      end
      id14_pkg::OP_RRF: begin
        res = {status_o.carry, a[7:1]};
        nc = a[0];
        zupd = 1'b0;
      end
      id14_pkg::OP_SWAPF: begin
        res = {a[3:0], a[7:4]};
        zupd = 1'b0;
      end
      id14_pkg::OP_BCF: begin
        res = a & ~bit_mask(dec.bitpos);
        zupd = 1'b0;
      end
      id14_pkg::OP_BSF: begin
        res = a | bit_mask(dec.bitpos);
        zupd = 1'b0;
      end
      id14_pkg::OP_BTFSC: begin
        zupd = 1'b0;
        skip = ((a & bit_mask(dec.bitpos)) == id14_pkg::BYTE_ZERO);
      end
      id14_pkg::OP_BTFSS: begin
        zupd = 1'b0;
        skip = ((a & bit_mask(dec.bitpos)) != id14_pkg::BYTE_ZERO);
      end
      default: zupd = 1'b0;
    endcase
  end

  always_comb begin
    next_phase = phase + 2'h1;
    next_cyc = (phase == id14_pkg::PH_WRITE);
    next_ir = ir;
    next_flush = flush;
    next_nop = nop_cycle_o;
    next_opnd = opnd;
    next_pc = prog_addr_o;
    next_rf_addr = rf_addr_o;
    next_rf_rd = 1'b0;
    next_rf_wr = 1'b0;
    next_rf_wdata = rf_wdata_o;
    next_pin_clr = 1'b0;
    next_psc_clr = 1'b0;
    next_wdt_clr = 1'b0;
    next_sleep = 1'b0;
    next_w = w_o;
    next_st = status_o;
    push = 1'b0;
    pop = 1'b0;
    unique case (phase)
      id14_pkg::PH_FETCH: begin
        // the cycle after a skip or jump runs as a no-op
        next_ir = flush ? id14_pkg::NOP_WORD : prog_data_i;
        next_nop = flush;
        next_flush = 1'b0;
      end
      id14_pkg::PH_READ: begin
        next_rf_addr = dec.faddr;
        next_rf_rd = dec.uses_file;
        next_pin_clr = dec.uses_file && dec.faddr == PORT_A_ADDR;
      end
      id14_pkg::PH_CALC: begin
        next_opnd = (rf_addr_o == PORT_A_ADDR) ? pin_sync : rf_rdata_i;
      end
      id14_pkg::PH_WRITE: begin
        next_rf_wr = dec.writes_file;
        next_rf_wdata = res;
        next_psc_clr = dec.writes_file && dec.faddr == TIMER0_ADDR &&
                       prescaler_assigned_i;
        if (dec.writes_w) begin
          next_w = res;
        end
        next_st.carry = nc;
        next_st.nibble_overflow_bit = ndc;
        if (zupd) begin
          next_st.zero = (res == id14_pkg::BYTE_ZERO);
        end
        if (dec.op == id14_pkg::OP_CLRWDT) begin
          next_st.timeout_flag = 1'b1;
          next_st.sleep_flag = 1'b1;
          next_wdt_clr = 1'b1;
        end
        if (dec.op == id14_pkg::OP_SLEEP) begin
          next_st.timeout_flag = 1'b1;
          next_st.sleep_flag = 1'b0;
          next_wdt_clr = 1'b1;
          next_sleep = 1'b1;
        end
        if (nop_cycle_o) begin
          next_pc = prog_addr_o;
        end else if (dec.op == id14_pkg::OP_GOTO ||
                     dec.op == id14_pkg::OP_CALL) begin
          next_pc = {prog_addr_o[PC_W-1:11], dec.target};
          push = (dec.op == id14_pkg::OP_CALL);
          next_flush = 1'b1;
        end else if (dec.op == id14_pkg::OP_RETURN ||
                     dec.op == id14_pkg::OP_RETFIE ||
                     dec.op == id14_pkg::OP_RETLW) begin
          next_pc = stack_top;
          pop = 1'b1;
          next_flush = 1'b1;
        end else if (skip) begin
          next_pc = prog_addr_o + PC_TWO;
          next_flush = 1'b1;
        end else begin
          next_pc = prog_addr_o + PC_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      phase <= id14_pkg::PH_FETCH;
      ir <= id14_pkg::NOP_WORD;
      flush <= 1'b0;
      opnd <= id14_pkg::BYTE_ZERO;
      prog_addr_o <= '0;
      rf_addr_o <= '0;
      rf_rd_o <= 1'b0;
      rf_wr_o <= 1'b0;
      rf_wdata_o <= id14_pkg::BYTE_ZERO;
      pin_change_clear_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
      wdt_clear_o <= 1'b0;
      sleep_req_o <= 1'b0;
      cycle_start_o <= 1'b0;
      nop_cycle_o <= 1'b0;
      w_o <= id14_pkg::W_RST;
      status_o <= id14_pkg::STATUS_RST;
    end else begin
      phase <= next_phase;
      ir <= next_ir;
      flush <= next_flush;
      opnd <= next_opnd;
      prog_addr_o <= next_pc;
      rf_addr_o <= next_rf_addr;
      rf_rd_o <= next_rf_rd;
      rf_wr_o <= next_rf_wr;
      rf_wdata_o <= next_rf_wdata;
      pin_change_clear_o <= next_pin_clr;
      prescaler_clear_o <= next_psc_clr;
      wdt_clear_o <= next_wdt_clr;
      sleep_req_o <= next_sleep;
      cycle_start_o <= next_cyc;
      nop_cycle_o <= next_nop;
      w_o <= next_w;
      status_o <= next_st;
    end
  end

  cycle_period_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
    else $error("instruction cycle is not four clocks");

  rmw_read_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rf_wr_o |-> $past(rf_rd_o, 2))
    else $error("register write without prior read");

  port_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rf_rd_o && rf_addr_o == PORT_A_ADDR) |-> pin_change_clear_o)
    else $error("port read did not clear pin change");

  flush_nop_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && next_flush) |-> ##2
    nop_cycle_o && ir == id14_pkg::NOP_WORD)
    else $error("skip or jump not followed by no-op cycle");

  dest_acc_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && dec.grp == id14_pkg::GRP_BYTE &&
     !dec.dest_f) |=> !rf_wr_o && w_o == $past(res))
    else $error("destination 0 did not go to accumulator");

  dest_file_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && dec.grp == id14_pkg::GRP_BYTE &&
     dec.dest_f) |=> rf_wr_o && rf_wdata_o == $past(res))
    else $error("destination 1 did not write register");

  read_addr_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rf_rd_o |-> rf_addr_o == ir[6:0] && rf_addr_o <= id14_pkg::FADDR_MAX)
    else $error("register address not from operand");

  bit_set_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && dec.op == id14_pkg::OP_BSF) |=>
    rf_wdata_o == ($past(opnd) | bit_mask($past(dec.bitpos))))
    else $error("bit set wrote wrong value");

  port_pins_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_CALC && rf_addr_o == PORT_A_ADDR) |=>
    opnd == $past(pin_sync))
    else $error("port operand not from pins");

  psc_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && dec.writes_file &&
     dec.faddr == TIMER0_ADDR && prescaler_assigned_i) |=> prescaler_clear_o)
    else $error("timer zero write kept prescaler");

  goto_tgt_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (phase == id14_pkg::PH_WRITE && !nop_cycle_o &&
     dec.op == id14_pkg::OP_GOTO) |=>
    prog_addr_o[10:0] == $past(ir[10:0]))
    else $error("jump target not from 11-bit literal");

endmodule : id14_core

`default_nettype wire

// *** id14_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(NM, EXP, GOT) begin cmp_count++; if ((GOT) !== (EXP)) begin \
  bad_count++; $display("Error %s expected %0h seen %0h", NM, EXP, GOT); \
  end end

module id14_core_tb;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] pins = 8'h00;
  logic asg = 1'b0;
  logic [12:0] pa;
  logic [13:0] pd;
  logic [6:0] ra;
  logic rd, wr, pcc, pre, cs, nop, wdc, slp;
  int wdc_n, slp_n;
  logic [7:0] wd, rdat, w_o;
  id14_pkg::id14_status_t st;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int pcc_n, pre_n, nop_n, rd_n;

  always #4 ref_clk_i = ~ref_clk_i;

  id14_core u_id14_core (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .prog_addr_o(pa),
    .prog_data_i(pd), .rf_addr_o(ra), .rf_rd_o(rd), .rf_wr_o(wr),
    .rf_wdata_o(wd), .rf_rdata_i(rdat), .port_pins_i(pins),
    .prescaler_assigned_i(asg), .pin_change_clear_o(pcc),
    .prescaler_clear_o(pre), .wdt_clear_o(wdc), .sleep_req_o(slp),
    .cycle_start_o(cs), .nop_cycle_o(nop), .w_o(w_o), .status_o(st)
  );

  id14_mem_model u_id14_mem_model (
    .ref_clk_i(ref_clk_i), .prog_addr_i(pa), .prog_data_o(pd),
    .rf_addr_i(ra), .rf_rd_i(rd), .rf_wr_i(wr), .rf_wdata_i(wd),
    .rf_rdata_o(rdat)
  );

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk_i) begin
    cyc_n++;
    if (pcc === 1'b1) pcc_n++;
    if (pre === 1'b1) pre_n++;
    if (nop === 1'b1) nop_n++;
    if (rd === 1'b1) rd_n++;
    if (wdc === 1'b1) wdc_n++;
    if (slp === 1'b1) slp_n++;
    if (cyc_n == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // clears memories, holds reset 5 clocks, then releases
  task automatic rst(input logic [7:0] p, input logic a);
    for (int i = 0; i < 64; i++) u_id14_mem_model.rom[i] = 14'h0000;
    for (int i = 0; i < 128; i++) u_id14_mem_model.regs[i] = 8'h00;
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    pins <= p;
    asg <= a;
    repeat (5) @(posedge ref_clk_i);
    pcc_n = 0; pre_n = 0; nop_n = 0; rd_n = 0; wdc_n = 0; slp_n = 0;
    srst_i <= 1'b0;
  endtask : rst

  task automatic run(input int n);
    repeat (4 * n + 1) @(posedge ref_clk_i);
    #1;
  endtask : run

  task automatic s_lit;
    int n;
    rst(8'h00, 1'b0);
    #1;
    `CHK("status_rst", 5'h18, st)
    `CHK("w_rst", 8'h00, w_o)
    u_id14_mem_model.rom[0] = 14'h335a; // load with ignored bits set
    u_id14_mem_model.rom[1] = 14'h3e0f;
    run(4);
    `CHK("w_lit", 8'h69, w_o)
    `CHK("nop_lit", 0, nop_n)
    n = 0;
    while (cs !== 1'b1) @(posedge ref_clk_i);
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (cs !== 1'b1);
    `CHK("cycle_len", 4, n)
    $display("s_lit done");
  endtask : s_lit

  task automatic s_byte;
    rst(8'h00, 1'b0);
    u_id14_mem_model.regs[7'h20] = 8'h10;
    u_id14_mem_model.regs[7'h21] = 8'h77;
    u_id14_mem_model.regs[7'h01] = 8'h09;
    u_id14_mem_model.rom[0] = 14'h0aa0;
    u_id14_mem_model.rom[1] = 14'h0821;
    u_id14_mem_model.rom[2] = 14'h00ff;
    u_id14_mem_model.rom[3] = 14'h0181;
    run(6);
    `CHK("incf_f", 8'h11, u_id14_mem_model.regs[7'h20])
    `CHK("movf_w", 8'h77, w_o)
    `CHK("movf_keep", 8'h77, u_id14_mem_model.regs[7'h21])
    `CHK("top_addr", 8'h77, u_id14_mem_model.regs[7'h7f])
    `CHK("register_clear_op_tmr", 8'h00, u_id14_mem_model.regs[7'h01])
    `CHK("reads", 4, rd_n)
    `CHK("pre_unasg", 0, pre_n)
    $display("s_byte done");
  endtask : s_byte

  task automatic s_bit;
    rst(8'h00, 1'b0);
    u_id14_mem_model.rom[0] = 14'h17b0;
    u_id14_mem_model.rom[1] = 14'h1530;
    u_id14_mem_model.rom[2] = 14'h1fb0;
    u_id14_mem_model.rom[3] = 14'h3011;
    u_id14_mem_model.rom[4] = 14'h3022;
    run(8);
    `CHK("bsf", 8'h84, u_id14_mem_model.regs[7'h30])
    `CHK("skip_w", 8'h22, w_o)
    `CHK("skip_nop", 4, nop_n)
    $display("s_bit done");
  endtask : s_bit

  task automatic s_goto;
    rst(8'h00, 1'b0);
    u_id14_mem_model.rom[0] = 14'h2805;
    u_id14_mem_model.rom[1] = 14'h3011;
    u_id14_mem_model.rom[5] = 14'h3044;
    run(5);
    `CHK("goto_w", 8'h44, w_o)
    `CHK("goto_nop", 4, nop_n)
    $display("s_goto done");
  endtask : s_goto

  task automatic s_port;
    rst(8'ha5, 1'b1);
    u_id14_mem_model.regs[7'h05] = 8'hff;
    u_id14_mem_model.regs[7'h01] = 8'h09;
    u_id14_mem_model.rom[0] = 14'h0805;
    u_id14_mem_model.rom[1] = 14'h0185;
    u_id14_mem_model.rom[2] = 14'h0181;
    run(6);
    `CHK("pin_read", 8'ha5, w_o)
    `CHK("pin_clr", 2, pcc_n)
    `CHK("port_zero", 8'h00, u_id14_mem_model.regs[7'h05])
    `CHK("pre_clr", 1, pre_n)
    `CHK("port_nop", 0, nop_n)
    $display("s_port done");
  endtask : s_port

  // call, literal return, then sleep and watchdog clear
  task automatic s_call;
    rst(8'h00, 1'b0);
    u_id14_mem_model.rom[0] = 14'h2004;
    u_id14_mem_model.rom[1] = 14'h0063;
    u_id14_mem_model.rom[2] = 14'h0064;
    u_id14_mem_model.rom[4] = 14'h3433;
    run(5);
    `CHK("ret_w", 8'h33, w_o)
    `CHK("sleep_st", 5'h10, st)
    `CHK("sleep_req", 1, slp_n)
    run(1);
    `CHK("wdt_st", 5'h18, st)
    `CHK("wdt_clr", 2, wdc_n)
    `CHK("call_nop", 8, nop_n)
    $display("s_call done");
  endtask : s_call

  initial begin
    s_lit();
    s_byte();
    s_bit();
    s_goto();
    s_port();
    s_call();
    tally_and_finish();
  end
endmodule : id14_core_tb

`default_nettype wire

// *** id14_decode.sv ***
`timescale 1ns/1ps
`default_nettype none

module id14_decode (
  input wire logic [13:0] word_i,
  output var id14_pkg::id14_dec_t dec_o
);

  always_comb begin
    // operand fields, 7-bit register and 3-bit position
    dec_o.faddr = word_i[6:0];
    dec_o.bitpos = word_i[9:7];
    dec_o.dest_f = word_i[7];
    dec_o.lit = word_i[7:0];
    dec_o.target = word_i[10:0];
    dec_o.op = id14_pkg::OP_NOP;
    // don't-care positions are wildcards
    casez (word_i)
      14'b00_0111_????_????: dec_o.op = id14_pkg::OP_ADDWF;
      14'b00_0101_????_????: dec_o.op = id14_pkg::OP_ANDWF;
      14'b00_0001_1???_????: dec_o.op = id14_pkg::OP_REG_CLEAR;
      14'b00_0001_0???_????: dec_o.op = id14_pkg::OP_CLRW;
      14'b00_1001_????_????: dec_o.op = id14_pkg::OP_COMF;
      14'b00_0011_????_????: dec_o.op = id14_pkg::OP_DECF;
      14'b00_1011_????_????: dec_o.op = id14_pkg::OP_DECFSZ;
      14'b00_1010_????_????: dec_o.op = id14_pkg::OP_INCF;
      14'b00_1111_????_????: dec_o.op = id14_pkg::OP_INCFSZ;
      14'b00_0100_????_????: dec_o.op = id14_pkg::OP_IORWF;
      14'b00_1000_????_????: dec_o.op = id14_pkg::OP_MOVF;
      14'b00_0000_1???_????: dec_o.op = id14_pkg::OP_MOVWF;
      14'b00_0000_0110_0100: dec_o.op = id14_pkg::OP_CLRWDT;
      14'b00_0000_0110_0011: dec_o.op = id14_pkg::OP_SLEEP;
      14'b00_0000_0000_1001: dec_o.op = id14_pkg::OP_RETFIE;
      14'b00_0000_0000_1000: dec_o.op = id14_pkg::OP_RETURN;
      14'b00_1101_????_????: dec_o.op = id14_pkg::OP_RLF;
      14'b00_1100_????_????: dec_o.op = id14_pkg::OP_RRF;
      14'b00_0010_????_????: dec_o.op = id14_pkg::OP_SUBWF;
      14'b00_1110_????_????: dec_o.op = id14_pkg::OP_SWAPF;
      14'b00_0110_????_????: dec_o.op = id14_pkg::OP_XORWF;
      14'b01_00??_????_????: dec_o.op = id14_pkg::OP_BCF;
      14'b01_01??_????_????: dec_o.op = id14_pkg::OP_BSF;
      14'b01_10??_????_????: dec_o.op = id14_pkg::OP_BTFSC;
      14'b01_11??_????_????: dec_o.op = id14_pkg::OP_BTFSS;
      14'b11_111?_????_????: dec_o.op = id14_pkg::OP_ADDLW;
      14'b11_1001_????_????: dec_o.op = id14_pkg::OP_ANDLW;
      14'b10_0???_????_????: dec_o.op = id14_pkg::OP_CALL;
      14'b10_1???_????_????: dec_o.op = id14_pkg::OP_GOTO;
      14'b11_1000_????_????: dec_o.op = id14_pkg::OP_IORLW;
      14'b11_00??_????_????: dec_o.op = id14_pkg::OP_MOVLW;
      14'b11_01??_????_????: dec_o.op = id14_pkg::OP_RETLW;
      14'b11_110?_????_????: dec_o.op = id14_pkg::OP_SUBLW;
      14'b11_1010_????_????: dec_o.op = id14_pkg::OP_XORLW;
      default: dec_o.op = id14_pkg::OP_NOP;
    endcase
    // three categories; control words with 00 prefix count as control
    if (word_i[13:12] == 2'b01) begin
      dec_o.grp = id14_pkg::GRP_BIT;
    end else if (word_i[13:12] == 2'b00 &&
                 dec_o.op != id14_pkg::OP_NOP &&
                 dec_o.op != id14_pkg::OP_CLRWDT &&
                 dec_o.op != id14_pkg::OP_SLEEP &&
                 dec_o.op != id14_pkg::OP_RETFIE &&
                 dec_o.op != id14_pkg::OP_RETURN) begin
      dec_o.grp = id14_pkg::GRP_BYTE;
    end else begin
      dec_o.grp = id14_pkg::GRP_LIT;
    end
    // every register-naming op reads it first, even write-only ones
    dec_o.uses_file = (dec_o.grp == id14_pkg::GRP_BIT) ||
                      (dec_o.grp == id14_pkg::GRP_BYTE &&
                       dec_o.op != id14_pkg::OP_CLRW);
    dec_o.writes_file = (dec_o.grp == id14_pkg::GRP_BYTE && dec_o.dest_f) ||
                        dec_o.op == id14_pkg::OP_BCF ||
                        dec_o.op == id14_pkg::OP_BSF;
    dec_o.writes_w = (dec_o.grp == id14_pkg::GRP_BYTE && !dec_o.dest_f) ||
                     dec_o.op == id14_pkg::OP_ADDLW ||
                     dec_o.op == id14_pkg::OP_ANDLW ||
                     dec_o.op == id14_pkg::OP_IORLW ||
                     dec_o.op == id14_pkg::OP_MOVLW ||
                     dec_o.op == id14_pkg::OP_RETLW ||
                     dec_o.op == id14_pkg::OP_SUBLW ||
                     dec_o.op == id14_pkg::OP_XORLW;
  end

endmodule : id14_decode

`default_nettype wire

// *** id14_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module id14_mem_model (
  input wire logic ref_clk_i,
  input wire logic [12:0] prog_addr_i,
  output logic [13:0] prog_data_o,
  input wire logic [6:0] rf_addr_i,
  input wire logic rf_rd_i,
  input wire logic rf_wr_i,
  input wire logic [7:0] rf_wdata_i,
  output logic [7:0] rf_rdata_o
);
  logic [13:0] rom [0:63];
  logic [7:0] regs [0:127];

  // zero-wait fetch of the whole word
  assign prog_data_o = rom[prog_addr_i[5:0]];
  // data only while strobed, inverted otherwise
  assign rf_rdata_o = rf_rd_i ? regs[rf_addr_i] : ~regs[rf_addr_i];

  always @(posedge ref_clk_i) begin
    if (rf_wr_i) begin
      regs[rf_addr_i] <= rf_wdata_i;
    end
  end
endmodule : id14_mem_model

`default_nettype wire

// *** id14_pkg.sv ***
package id14_pkg;

  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BITPOS_W = 3;
  localparam int unsigned LIT_W = 8;
  localparam int unsigned TARGET_W = 11;

  // instruction-cycle timing
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam int unsigned REF_CLK_MHZ = 125;
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_CALC = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'(OSC_PER_CYCLE - 1);

  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [6:0] FADDR_MAX = 7'h7f;
  localparam logic [6:0] TIMER0_ADDR_DEF = 7'h01;
  localparam logic [6:0] PORT_A_ADDR_DEF = 7'h05;

  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [4:0] STATUS_RST = 5'h18;

  typedef enum logic [1:0] {
    GRP_BYTE,
    GRP_BIT,
    GRP_LIT
  } id14_grp_t;

  typedef enum logic [5:0] {
    OP_ADDWF, OP_ANDWF, OP_REG_CLEAR, OP_CLRW, OP_COMF, OP_DECF, OP_DECFSZ,
    OP_INCF, OP_INCFSZ, OP_IORWF, OP_MOVF, OP_MOVWF, OP_NOP, OP_RLF,
    OP_RRF, OP_SUBWF, OP_SWAPF, OP_XORWF, OP_BCF, OP_BSF, OP_BTFSC,
    OP_BTFSS, OP_ADDLW, OP_ANDLW, OP_CALL, OP_CLRWDT, OP_GOTO, OP_IORLW,
    OP_MOVLW, OP_RETFIE, OP_RETLW, OP_RETURN, OP_SLEEP, OP_SUBLW, OP_XORLW
  } id14_op_t;

  typedef struct packed {
    id14_grp_t grp;
    id14_op_t op;
    logic dest_f;
    logic [6:0] faddr;
    logic [2:0] bitpos;
    logic [7:0] lit;
    logic [10:0] target;
    logic uses_file;
    logic writes_file;
    logic writes_w;
  } id14_dec_t;

  typedef struct packed {
    logic timeout_flag;
    logic sleep_flag;
    logic zero;
    logic nibble_overflow_bit;
    logic carry;
  } id14_status_t;

endpackage : id14_pkg

// *** id14_stack.sv ***
`timescale 1ns/1ps
`default_nettype none

module id14_stack #(
  parameter int unsigned W = 13,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] push_data_i,
  output logic [W-1:0] top_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = 1;
  localparam logic [AW-1:0] PTR_TWO = 2;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] ptr;
  logic [AW-1:0] next_ptr;
  logic [W-1:0] next_top;

  // circular: overflow overwrites the oldest entry
  always_comb begin
    next_ptr = ptr;
    next_top = top_o;
    if (push_i) begin
      next_ptr = ptr + PTR_ONE;
      next_top = push_data_i;
    end else if (pop_i) begin
      next_ptr = ptr - PTR_ONE;
      next_top = mem[ptr - PTR_TWO];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ptr <= '0;
      top_o <= '0;
    end else begin
      ptr <= next_ptr;
      top_o <= next_top;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push_i) begin
      mem[ptr] <= push_data_i;
    end
  end

endmodule : id14_stack

`default_nettype wire
